/* design/utr_pkg.sv */
// Shared constants, types and helpers for the serial transmit/receive block
// Function
// - Buffer-empty flag is set while transmit holding buffer is empty.
// - Buffer-empty interrupt stays asserted while flag, enable and global enable hold.
// - Writing the data register clears the buffer-empty flag.
// - Transmit-complete sets when frame shifted out and holding buffer is empty.
// - Transmit-complete clears on interrupt service or on writing one.
// - Transmit-complete interrupt requested when flag sets with enables on.
// - Parity enable bit set inserts parity after last data bit.
// - Transmitter disable waits until shifter and holding buffer are empty.
// - Effectively disabled transmitter releases the serial output pin.
// - Receiver enable hands the serial input pin to the receiver.
// - Synchronous mode takes bit timing from the external bit clock pin.
// - Receiver starts on valid start bit and shifts bits until first stop.
// - Receiver ignores any second stop bit.
// - First stop bit moves the frame into the receive buffer.
// - Narrow characters read back with zeros in unused upper bits.
// - Ninth bit and error flags are stored per receive buffer entry.
// - Shifter loads buffered character when idle or right after last stop.
// - Receive-complete tracks unread data; disabling receiver flushes the buffer.
// - Two-entry receive buffer; overrun on full, waiting char and new start.
package utr_pkg;

  localparam logic [31:0] OFS_DATA = 32'h0000_0000;
  localparam logic [31:0] OFS_STATUS = 32'h0000_0004;
  localparam logic [31:0] OFS_CTRLB = 32'h0000_0008;
  localparam logic [31:0] OFS_CTRLC = 32'h0000_000C;

  localparam int unsigned ST_RXC = 7;
  localparam int unsigned ST_TXC = 6;
  localparam int unsigned ST_UDRE = 5;
  localparam int unsigned ST_FE = 4;
  localparam int unsigned ST_DOR = 3;
  localparam int unsigned ST_UPE = 2;

  localparam int unsigned CB_RXCIE = 7;
  localparam int unsigned CB_TXCIE = 6;
  localparam int unsigned CB_UDRIE = 5;
  localparam int unsigned CB_RXEN = 4;
  localparam int unsigned CB_TXEN = 3;
  localparam int unsigned CB_UCSZ2 = 2;
  localparam int unsigned CB_RXB8 = 1;
  localparam int unsigned CB_TXB8 = 0;

  localparam int unsigned CC_SYNC = 6;
  localparam int unsigned CC_UPM1 = 5;
  localparam int unsigned CC_UPM0 = 4;
  localparam int unsigned CC_USBS = 3;
  localparam int unsigned CC_UCSZ1 = 2;
  localparam int unsigned CC_UCSZ0 = 1;

  localparam logic [7:0] CTRLB_RST = 8'h00;
  localparam logic [7:0] CTRLC_RST = 8'h06;
  localparam logic [1:0] RX_DEPTH = 2'h2;
  localparam logic [2:0] UCSZ_NINE = 3'h7;
  localparam int unsigned FRAME_W = 13;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_DATA = 2'b01,
    RX_PAR = 2'b10,
    RX_STOP = 2'b11
  } utr_rx_st_e;

  typedef struct packed {
    logic sync;
    logic [1:0] upm;
    logic usbs;
    logic [2:0] ucsz;
  } utr_cfg_s;

  typedef struct packed {
    logic ninth;
    logic [7:0] data;
  } utr_tx_char_s;

  typedef struct packed {
    logic ninth;
    logic fe;
    logic dor;
    logic upe;
    logic [7:0] data;
  } utr_rx_ent_s;

  function automatic logic [3:0] data_bits(input logic [2:0] ucsz);
    if (ucsz == UCSZ_NINE) begin
      return 4'h9;
    end
    return {2'h0, ucsz[1:0]} + 4'h5;
  endfunction : data_bits

  function automatic logic parity(input logic [8:0] d, input logic [3:0] n, input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < n) begin
        p = p ^ d[i];
      end
    end
    return p;
  endfunction : parity

endpackage : utr_pkg

/* design/utr_rx.sv */
// Receive shift register: start detection, data shift and first stop check
`timescale 1ns/100ps
module utr_rx (
  input wire logic i_clk,               // Core clock
  input wire logic i_rst,               // Synchronous reset, high
  input wire logic i_ce,                // Clock enable
  input wire logic i_tick,              // Bit sampling instant
  input wire logic i_en,                // Receiver enable; low aborts
  input wire logic i_rxd,               // Serial input
  input wire utr_pkg::utr_cfg_s i_cfg,  // Frame format
  output logic o_start,                 // Start bit seen, one cycle
  output logic o_vld,                   // Frame complete, one cycle
  output utr_pkg::utr_rx_ent_s o_ent    // Completed frame and status
);
  utr_pkg::utr_rx_st_e st_ff;
  logic [8:0] sh_ff;
  logic [3:0] cnt_ff;
  logic par_ff;
  logic [3:0] nbits;
  logic step;

  assign nbits = utr_pkg::data_bits(i_cfg.ucsz);
  assign step = i_ce & i_en & i_tick;
  assign o_start = step & (st_ff == utr_pkg::RX_IDLE) & !i_rxd;

  always_ff @(posedge i_clk) begin
    if (i_rst || (i_ce && !i_en)) begin
      st_ff <= utr_pkg::RX_IDLE;
      sh_ff <= '0;
      cnt_ff <= 4'h0;
      par_ff <= 1'h0;
      o_vld <= 1'h0;
      o_ent <= '0;
    end else if (i_ce) begin
      o_vld <= 1'h0;
      if (step) begin
        case (st_ff)
          utr_pkg::RX_IDLE: begin
            // Idle high level between frames also swallows a second stop bit
            if (!i_rxd) begin
              st_ff <= utr_pkg::RX_DATA;
              sh_ff <= '0;
              cnt_ff <= 4'h0;
            end
          end
          utr_pkg::RX_DATA: begin
            sh_ff[cnt_ff] <= i_rxd;
            cnt_ff <= cnt_ff + 4'h1;
            if (cnt_ff == nbits - 4'h1) begin
              st_ff <= i_cfg.upm[1] ? utr_pkg::RX_PAR : utr_pkg::RX_STOP;
            end
          end
          utr_pkg::RX_PAR: begin
            par_ff <= i_rxd;
            st_ff <= utr_pkg::RX_STOP;
          end
          utr_pkg::RX_STOP: begin
            o_vld <= 1'h1;
            o_ent.ninth <= sh_ff[8];
            o_ent.data <= sh_ff[7:0];
            o_ent.fe <= !i_rxd;
            o_ent.dor <= 1'h0;
            o_ent.upe <= i_cfg.upm[1] &
                         (par_ff != utr_pkg::parity(sh_ff, nbits, i_cfg.upm[0]));
            st_ff <= utr_pkg::RX_IDLE;
          end
          default: st_ff <= utr_pkg::RX_IDLE;
        endcase
      end
    end
  end
endmodule : utr_rx

/* design/utr_top.sv */
// Serial transmitter/receiver status logic with AHB-Lite register slave
//
// Our own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
module utr_top (
  input wire logic I_CORE_CLK,        // Core clock, 125 MHz
  input wire logic I_RST,             // Synchronous reset, high
  input wire logic I_CE,              // Clock enable, low freezes all
  input wire logic I_HSEL,            // AHB slave select
  input wire logic [31:0] I_HADDR,    // AHB address
  input wire logic [1:0] I_HTRANS,    // AHB transfer type
  input wire logic I_HWRITE,          // AHB write
  input wire logic [2:0] I_HSIZE,     // AHB size, word only
  input wire logic [31:0] I_HWDATA,   // AHB write data
  input wire logic I_HREADY,          // AHB bus ready
  output logic [31:0] O_HRDATA,       // AHB read data
  output logic O_HREADYOUT,           // AHB slave ready
  output logic O_HRESP,               // AHB response, always OKAY
  input wire logic I_GIE,             // Global interrupt enable
  input wire logic I_TXC_IRQ_ACK,     // Transmit-complete irq serviced
  input wire logic I_BIT_TICK,        // Baud tick from bit timing source
  input wire logic I_XCK,             // External bit clock pin level
  input wire logic I_RXD,             // Serial input pin
  output logic O_TXD,                 // Serial output value
  output logic O_TXD_OVERRIDE,        // Transmitter owns output pin
  output logic O_RXD_OVERRIDE,        // Receiver owns input pin
  output logic O_IRQ_RXC,             // Receive-complete request
  output logic O_IRQ_UDRE,            // Buffer-empty request
  output logic O_IRQ_TXC              // Transmit-complete request
);
  logic rd_pend_ff;
  logic wr_pend_ff;
  logic [31:0] addr_ff;
  logic [31:0] hrdata_ff;
  logic bus_acc;
  logic hit_data;
  logic hit_status;
  logic hit_ctrlb;
  logic hit_ctrlc;
  logic wr_data;
  logic wr_status;
  logic [31:0] rd_val;

  logic [7:0] ctrlb_ff;
  logic [7:0] ctrlc_ff;
  utr_pkg::utr_cfg_s cfg;
  logic xck_q_ff;
  logic tick;

  utr_pkg::utr_tx_char_s tx_buf_ff;
  logic tx_buf_vld_ff;
  logic txc_ff;
  logic tx_on_ff;
  logic tx_load;
  logic tx_busy;
  logic tx_done;
  logic tx_txd;
  logic txc_set;
  logic txc_clr;
  logic udre;

  utr_pkg::utr_rx_ent_s rx_mem_ff [0:1];
  utr_pkg::utr_rx_ent_s pend_ff;
  utr_pkg::utr_rx_ent_s rx_ent;
  utr_pkg::utr_rx_ent_s push_src;
  utr_pkg::utr_rx_ent_s push_ent;
  utr_pkg::utr_rx_ent_s rx_head;
  logic [1:0] rx_cnt_ff;
  logic rx_wp_ff;
  logic rx_rp_ff;
  logic pend_vld_ff;
  logic dor_pend_ff;
  logic rx_en;
  logic rx_start;
  logic rx_vld;
  logic rx_full;
  logic rx_pop;
  logic push_pend;
  logic push_new;
  logic push;
  logic ovr_set;
  logic rxc;
  logic [7:0] st_val;
  logic [7:0] cb_val;

  // Bus decode
  assign bus_acc = I_HSEL & I_HTRANS[1] & I_HREADY;
  assign hit_data = addr_ff == utr_pkg::OFS_DATA;
  assign hit_status = addr_ff == utr_pkg::OFS_STATUS;
  assign hit_ctrlb = addr_ff == utr_pkg::OFS_CTRLB;
  assign hit_ctrlc = addr_ff == utr_pkg::OFS_CTRLC;
  assign wr_data = I_CE & wr_pend_ff & hit_data;
  assign wr_status = I_CE & wr_pend_ff & hit_status;
  // Reads take one wait state so a write just before is already visible
  assign O_HREADYOUT = I_CE & !rd_pend_ff;
  assign O_HRESP = 1'h0;
  assign O_HRDATA = hrdata_ff;

  assign rd_val = hit_data ? {24'h0, rx_head.data & {8{rxc}}} :
                  hit_status ? {24'h0, st_val} :
                  hit_ctrlb ? {24'h0, cb_val} :
                  hit_ctrlc ? {24'h0, ctrlc_ff} :
                  32'h0000_0000;

  always_comb begin
    st_val = 8'h00;
    st_val[utr_pkg::ST_RXC] = rxc;
    st_val[utr_pkg::ST_TXC] = txc_ff;
    st_val[utr_pkg::ST_UDRE] = udre;
    st_val[utr_pkg::ST_FE] = rxc & rx_head.fe;
    st_val[utr_pkg::ST_DOR] = rxc & rx_head.dor;
    st_val[utr_pkg::ST_UPE] = rxc & rx_head.upe;
    cb_val = ctrlb_ff;
    cb_val[utr_pkg::CB_RXB8] = rxc & rx_head.ninth;
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      rd_pend_ff <= 1'h0;
      wr_pend_ff <= 1'h0;
      addr_ff <= 32'h0000_0000;
    end else if (I_CE) begin
      rd_pend_ff <= bus_acc & !I_HWRITE;
      wr_pend_ff <= bus_acc & I_HWRITE;
      if (bus_acc) begin
        addr_ff <= I_HADDR;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (I_CE && rd_pend_ff) begin
      hrdata_ff <= rd_val;
    end
  end

  // Control registers
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      ctrlb_ff <= utr_pkg::CTRLB_RST;
      ctrlc_ff <= utr_pkg::CTRLC_RST;
    end else if (I_CE && wr_pend_ff) begin
      if (hit_ctrlb) begin
        ctrlb_ff <= I_HWDATA[7:0];
      end
      if (hit_ctrlc) begin
        ctrlc_ff <= I_HWDATA[7:0];
      end
    end
  end

  assign cfg = {ctrlc_ff[utr_pkg::CC_SYNC], ctrlc_ff[utr_pkg::CC_UPM1],
                ctrlc_ff[utr_pkg::CC_UPM0], ctrlc_ff[utr_pkg::CC_USBS],
                ctrlb_ff[utr_pkg::CB_UCSZ2], ctrlc_ff[utr_pkg::CC_UCSZ1],
                ctrlc_ff[utr_pkg::CC_UCSZ0]};
  assign rx_en = ctrlb_ff[utr_pkg::CB_RXEN];

  // Bit timing: rising edge of the external clock in synchronous mode
  assign tick = cfg.sync ? (I_XCK & !xck_q_ff) : I_BIT_TICK;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      xck_q_ff <= 1'h0;
    end else if (I_CE) begin
      xck_q_ff <= I_XCK;
    end
  end

  // Transmit side
  assign udre = !tx_buf_vld_ff;
  assign txc_set = tx_done & !tx_buf_vld_ff;
  assign txc_clr = I_CE & (I_TXC_IRQ_ACK | (wr_status & I_HWDATA[utr_pkg::ST_TXC]));
  assign O_TXD = tx_txd;
  assign O_TXD_OVERRIDE = tx_on_ff;
  assign O_IRQ_UDRE = udre & ctrlb_ff[utr_pkg::CB_UDRIE] & I_GIE;
  assign O_IRQ_TXC = txc_ff & ctrlb_ff[utr_pkg::CB_TXCIE] & I_GIE;

  utr_tx u_tx (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_ce(I_CE),
    .i_tick(tick),
    .i_en(tx_on_ff),
    .i_load_vld(tx_buf_vld_ff),
    .i_char(tx_buf_ff),
    .i_cfg(cfg),
    .o_load(tx_load),
    .o_busy(tx_busy),
    .o_done(tx_done),
    .o_txd(tx_txd)
  );

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      tx_buf_ff <= '0;
      tx_buf_vld_ff <= 1'h0;
    end else if (wr_data) begin
      // Ninth bit is taken from the control register at the low-byte write
      tx_buf_ff <= {ctrlb_ff[utr_pkg::CB_TXB8], I_HWDATA[7:0]};
      tx_buf_vld_ff <= 1'h1;
    end else if (tx_load) begin
      tx_buf_vld_ff <= 1'h0;
    end
  end

  // Hardware set wins over any clear in the same cycle
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      txc_ff <= 1'h0;
    end else if (I_CE) begin
      txc_ff <= txc_set | (txc_ff & !txc_clr);
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      tx_on_ff <= 1'h0;
    end else if (I_CE) begin
      tx_on_ff <= ctrlb_ff[utr_pkg::CB_TXEN] |
                  (tx_on_ff & (tx_busy | tx_buf_vld_ff));
    end
  end

  // Receive side
  assign O_RXD_OVERRIDE = rx_en;
  assign rxc = rx_cnt_ff != 2'h0;
  assign O_IRQ_RXC = rxc & ctrlb_ff[utr_pkg::CB_RXCIE] & I_GIE;
  assign rx_head = rx_mem_ff[rx_rp_ff];
  assign rx_full = rx_cnt_ff == utr_pkg::RX_DEPTH;
  assign rx_pop = I_CE & rd_pend_ff & hit_data & rxc;
  assign push_pend = pend_vld_ff & !rx_full;
  assign push_new = rx_vld & !pend_vld_ff & !rx_full;
  assign push = I_CE & (push_pend | push_new);
  assign push_src = push_pend ? pend_ff : rx_ent;
  assign push_ent = {push_src.ninth, push_src.fe, dor_pend_ff, push_src.upe, push_src.data};
  // Full buffer, a frame waiting and a fresh start bit: data will be lost
  assign ovr_set = rx_start & rx_full & pend_vld_ff;

  utr_rx u_rx (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_ce(I_CE),
    .i_tick(tick),
    .i_en(rx_en),
    .i_rxd(I_RXD),
    .i_cfg(cfg),
    .o_start(rx_start),
    .o_vld(rx_vld),
    .o_ent(rx_ent)
  );

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST || (I_CE && !rx_en)) begin
      rx_cnt_ff <= 2'h0;
      rx_wp_ff <= 1'h0;
      rx_rp_ff <= 1'h0;
    end else if (I_CE) begin
      rx_cnt_ff <= rx_cnt_ff + {1'h0, push} - {1'h0, rx_pop};
      rx_wp_ff <= rx_wp_ff ^ push;
      rx_rp_ff <= rx_rp_ff ^ rx_pop;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (push) begin
      rx_mem_ff[rx_wp_ff] <= push_ent;
    end
  end

  // A newer frame overwrites one still waiting; the overrun flag records it
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST || (I_CE && !rx_en)) begin
      pend_ff <= '0;
      pend_vld_ff <= 1'h0;
      dor_pend_ff <= 1'h0;
    end else if (I_CE) begin
      if (rx_vld && !push_new) begin
        pend_ff <= rx_ent;
        pend_vld_ff <= 1'h1;
      end else if (push_pend) begin
        pend_vld_ff <= 1'h0;
      end
      dor_pend_ff <= ovr_set | (dor_pend_ff & !push);
    end
  end

  // Checks
  a_udre_write_clear: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    wr_data |=> !udre && !O_IRQ_UDRE) else $error("buffer-empty not cleared by write");
  a_udre_load_set: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    tx_load && !wr_data |=> udre) else $error("buffer-empty not set after load");
  a_udre_irq_level: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    udre && ctrlb_ff[utr_pkg::CB_UDRIE] && I_GIE |-> O_IRQ_UDRE)
    else $error("buffer-empty request missing");
  a_txc_frame_set: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    tx_done && !tx_buf_vld_ff |=> txc_ff) else $error("transmit-complete not set");
  a_txc_ack_clear: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    txc_clr && !txc_set |=> !txc_ff) else $error("transmit-complete not cleared");
  a_txc_irq_rise: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    $rose(txc_ff) && ctrlb_ff[utr_pkg::CB_TXCIE] && I_GIE |-> O_IRQ_TXC)
    else $error("transmit-complete request missing");
  a_tx_off_deferred: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    I_CE && tx_on_ff && (tx_busy || tx_buf_vld_ff) |=> O_TXD_OVERRIDE)
    else $error("transmitter released early");
  a_txd_pin_release: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    I_CE && !ctrlb_ff[utr_pkg::CB_TXEN] && !tx_busy && !tx_buf_vld_ff |=> !O_TXD_OVERRIDE)
    else $error("output pin not released");
  a_rx_flush_empty: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    I_CE && !rx_en |=> !rxc ##1 !rxc || rx_en) else $error("receive buffer not flushed");
  a_rx_frame_store: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    I_CE && rx_en && push_new |=> rxc) else $error("frame not stored");
  a_rx_overrun_flag: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    I_CE && rx_en && ovr_set |=> dor_pend_ff) else $error("overrun not recorded");
endmodule : utr_top

/* design/utr_tx.sv */
// Transmit shift register: frame build, parity insertion and bit shifting
`timescale 1ns/100ps
module utr_tx (
  input wire logic i_clk,                  // Core clock
  input wire logic i_rst,                  // Synchronous reset, high
  input wire logic i_ce,                   // Clock enable
  input wire logic i_tick,                 // One bit period elapsed
  input wire logic i_en,                   // Transmitter effectively on
  input wire logic i_load_vld,             // Holding buffer has a character
  input wire utr_pkg::utr_tx_char_s i_char, // Buffered character
  input wire utr_pkg::utr_cfg_s i_cfg,     // Frame format
  output logic o_load,                     // Buffer moved into shifter
  output logic o_busy,                     // Frame in progress
  output logic o_done,                     // Last stop bit finished
  output logic o_txd                       // Serial output value
);
  logic [utr_pkg::FRAME_W-1:0] sh_ff;
  logic [utr_pkg::FRAME_W-1:0] frame;
  logic [3:0] cnt_ff;
  logic [3:0] len;
  logic busy_ff;
  logic last;
  logic [3:0] nbits;
  logic [8:0] dword;

  assign nbits = utr_pkg::data_bits(i_cfg.ucsz);
  assign dword = {i_char.ninth, i_char.data};
  assign last = busy_ff & i_tick & (cnt_ff == 4'h1);
  assign o_done = i_ce & last;
  // Load when idle or on the tick that ends the previous stop bit
  assign o_load = i_ce & i_en & i_load_vld & (!busy_ff | last);
  assign o_busy = busy_ff;
  assign o_txd = sh_ff[0];

  always_comb begin
    frame = '1;
    frame[0] = 1'h0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < nbits) begin
        frame[i + 1] = dword[i];
      end
    end
    if (i_cfg.upm[1]) begin
      frame[nbits + 4'h1] = utr_pkg::parity(dword, nbits, i_cfg.upm[0]);
    end
    len = nbits + 4'h2 + {3'h0, i_cfg.upm[1]} + {3'h0, i_cfg.usbs};
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sh_ff <= '1;
      cnt_ff <= 4'h0;
      busy_ff <= 1'h0;
    end else if (o_load) begin
      sh_ff <= frame;
      cnt_ff <= len;
      busy_ff <= 1'h1;
    end else if (i_ce && busy_ff && i_tick) begin
      sh_ff <= {1'h1, sh_ff[utr_pkg::FRAME_W-1:1]};
      cnt_ff <= cnt_ff - 4'h1;
      busy_ff <= !last;
    end
  end
endmodule : utr_tx

/* dv/tb_utr_top.sv */
// Self-checking bench for the serial transmit/receive block
`timescale 1ns/100ps
module tb_utr_top;
  logic clk = 1'b0, rst = 1'b1, hw = 1'b0, gie = 1'b0, ack = 1'b0, tick = 1'b0;
  logic sync_on = 1'b0;
  logic [1:0] htr = 2'h0;
  logic [2:0] tc = 3'h0;
  logic [31:0] ha = 32'h0, hwd = 32'h0, rd, hrdata;
  logic hrdy, hresp, txd, txo, rxo, irq_rxc, irq_udre, irq_txc, rxd;
  int error_cnt = 0, num_checks = 0;
  always #4 clk = ~clk;
  // Bit strobe every eight core cycles keeps the run short
  always @(posedge clk) begin
    tc <= tc + 3'h1;
    tick <= &tc;
  end
  utr_top dut (
    .I_CORE_CLK(clk), .I_RST(rst), .I_CE(1'b1), .I_HSEL(1'b1), .I_HADDR(ha),
    .I_HTRANS(htr), .I_HWRITE(hw), .I_HSIZE(3'h2), .I_HWDATA(hwd), .I_HREADY(hrdy),
    .O_HRDATA(hrdata), .O_HREADYOUT(hrdy), .O_HRESP(hresp), .I_GIE(gie),
    // In synchronous mode only the external clock pin carries the strobe
    .I_TXC_IRQ_ACK(ack), .I_BIT_TICK(tick & !sync_on), .I_XCK(tick & sync_on),
    .I_RXD(rxd), .O_TXD(txd),
    .O_TXD_OVERRIDE(txo), .O_RXD_OVERRIDE(rxo), .O_IRQ_RXC(irq_rxc),
    .O_IRQ_UDRE(irq_udre), .O_IRQ_TXC(irq_txc)
  );
  utr_peer peer (.clk(clk), .tick(tick), .txd(txd), .rxd(rxd));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hrdy !== 1'b1 && n < 64);
    if (n >= 64) begin
      error_cnt++;
      end_sim();
    end
  endtask : wait_rdy
  // Entered right after a rising edge; read data taken at the closing edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hw <= w;
    ha <= a;
    htr <= 2'h2;
    wait_rdy();
    htr <= 2'h0;
    hwd <= d;
    wait_rdy();
    rd = hrdata;
  endtask : bus
  task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask : rchk
  task automatic test_tx;
    int n;
    gie <= 1'b1;
    bus(1'b1, utr_pkg::OFS_CTRLC, 32'h26);
    bus(1'b1, utr_pkg::OFS_CTRLB, 32'h28);
    rchk("status idle", utr_pkg::OFS_STATUS, 32'h20);
    chk("udre irq on", 32'(irq_udre), 32'h1);
    chk("hresp okay", 32'(hresp), 32'h0);
    bus(1'b1, utr_pkg::OFS_DATA, 32'hA5);
    // Second char waits in the holding buffer behind the first
    bus(1'b1, utr_pkg::OFS_DATA, 32'h3C);
    rchk("status full", utr_pkg::OFS_STATUS, 32'h00);
    chk("udre irq off", 32'(irq_udre), 32'h0);
    bus(1'b1, utr_pkg::OFS_CTRLB, 32'h40);
    // Enable bit is already low here; the pin must still be held
    repeat (2) @(posedge clk);
    chk("tx pin held", 32'(txo), 32'h1);
    for (n = 0; n < 600 && txo !== 1'b0; n++)
      @(posedge clk);
    if (n >= 600) begin
      error_cnt++;
      end_sim();
    end
    chk("tx pin free", 32'(txo), 32'h0);
    chk("tx frame", 32'(peer.fr), 32'h23C);
    chk("txc irq", 32'(irq_txc), 32'h1);
    rchk("status done", utr_pkg::OFS_STATUS, 32'h60);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    rchk("txc serviced", utr_pkg::OFS_STATUS, 32'h20);
    // Nine bits with parity: ninth bit set in control before the low byte
    bus(1'b1, utr_pkg::OFS_CTRLB, 32'h4D);
    bus(1'b1, utr_pkg::OFS_DATA, 32'h55);
    for (n = 0; n < 300 && irq_txc !== 1'b1; n++)
      @(posedge clk);
    if (n >= 300) begin
      error_cnt++;
      end_sim();
    end
    chk("tx nine frame", 32'(peer.fr), 32'h355);
    // Write one to clear, buffer-empty position written as zero
    bus(1'b1, utr_pkg::OFS_STATUS, 32'h40);
    rchk("txc written", utr_pkg::OFS_STATUS, 32'h20);
    chk("txc irq off", 32'(irq_txc), 32'h0);
    $display("test tx done");
  endtask : test_tx
  task automatic test_rx;
    // Two stop bits set, peer sends one: only the first is judged
    bus(1'b1, utr_pkg::OFS_CTRLC, 32'h08);
    bus(1'b1, utr_pkg::OFS_CTRLB, 32'h90);
    @(posedge clk);
    chk("rx pin", 32'(rxo), 32'h1);
    peer.send(10'h03D, 6);
    peer.send(10'h00A, 6);
    repeat (3) @(posedge clk);
    rchk("rx status a", utr_pkg::OFS_STATUS, 32'hA0);
    chk("rxc irq on", 32'(irq_rxc), 32'h1);
    rchk("rx data a", utr_pkg::OFS_DATA, 32'h1D);
    rchk("rx status b", utr_pkg::OFS_STATUS, 32'hB0);
    rchk("rx data b", utr_pkg::OFS_DATA, 32'h0A);
    rchk("rx empty", utr_pkg::OFS_STATUS, 32'h20);
    chk("rxc irq off", 32'(irq_rxc), 32'h0);
    // Two queued, one waiting, then a fourth start bit: the third is lost
    peer.send(10'h021, 6);
    peer.send(10'h022, 6);
    peer.send(10'h023, 6);
    peer.send(10'h024, 6);
    repeat (3) @(posedge clk);
    rchk("ovr status 1", utr_pkg::OFS_STATUS, 32'hA0);
    rchk("ovr data 1", utr_pkg::OFS_DATA, 32'h01);
    rchk("ovr status 2", utr_pkg::OFS_STATUS, 32'hA0);
    rchk("ovr data 2", utr_pkg::OFS_DATA, 32'h02);
    rchk("ovr status 4", utr_pkg::OFS_STATUS, 32'hA8);
    rchk("ovr data 4", utr_pkg::OFS_DATA, 32'h04);
    peer.send(10'h03F, 6);
    repeat (3) @(posedge clk);
    rchk("rx one", utr_pkg::OFS_STATUS, 32'hA0);
    bus(1'b1, utr_pkg::OFS_CTRLB, 32'h00);
    @(posedge clk);
    chk("rx pin free", 32'(rxo), 32'h0);
    rchk("rx flushed", utr_pkg::OFS_STATUS, 32'h20);
    $display("test rx done");
  endtask : test_rx
  task automatic test_rx_mode;
    // Nine data bits: ninth bit read from the control register before the low byte
    bus(1'b1, utr_pkg::OFS_CTRLC, 32'h06);
    bus(1'b1, utr_pkg::OFS_CTRLB, 32'h14);
    peer.send(10'h3A5, 10);
    repeat (3) @(posedge clk);
    rchk("rx ninth", utr_pkg::OFS_CTRLB, 32'h16);
    rchk("rx low byte", utr_pkg::OFS_DATA, 32'hA5);
    rchk("rx ninth gone", utr_pkg::OFS_CTRLB, 32'h14);
    // Baud strobe held off, so only the external clock can time the frame
    bus(1'b1, utr_pkg::OFS_CTRLB, 32'h10);
    bus(1'b1, utr_pkg::OFS_CTRLC, 32'h46);
    sync_on <= 1'b1;
    peer.send(10'h15A, 9);
    repeat (3) @(posedge clk);
    rchk("rx sync", utr_pkg::OFS_DATA, 32'h5A);
    sync_on <= 1'b0;
    $display("test rx modes done");
  endtask : test_rx_mode
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    test_tx();
    test_rx();
    test_rx_mode();
    end_sim();
  end
endmodule : tb_utr_top

/* dv/utr_peer.sv */
// Remote serial peer: frame capture on the output line, frame drive on the input line
`timescale 1ns/100ps
module utr_peer (
  input wire logic clk,  // Core clock
  input wire logic tick, // Bit period strobe
  input wire logic txd,  // Line from the block
  output logic rxd       // Line into the block
);
  logic [3:0] cnt = 4'h0;
  logic [9:0] fr = 10'h000;
  // Mark level while idle, as the line pull-up gives
  initial rxd = 1'b1;
  // Ten samples per frame: eight data, parity, stop, or nine data and parity
  always @(posedge clk) begin
    if (tick) begin
      if (cnt == 4'h0) begin
        if (txd == 1'b0) cnt <= 4'h1;
      end else begin
        fr <= {txd, fr[9:1]};
        cnt <= (cnt == 4'hA) ? 4'h0 : cnt + 4'h1;
      end
    end
  end
  // Start bit, then n bits LSB first, each held from one tick to the next
  task automatic send(input logic [9:0] bits, input int n);
    @(posedge clk iff tick);
    rxd <= 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk iff tick);
      rxd <= bits[i];
    end
    @(posedge clk iff tick);
    rxd <= 1'b1;
  endtask : send
endmodule : utr_peer
